// ==== sim/nv_memory_write_protect_test.sv ====
`include "nvwp_cfg.svh"
module nv_memory_write_protect_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WC = 2;
   localparam int PW = 24;
   typedef struct {
      logic [31:0] data;
      logic        err;
      logic        rd;
   } nvwp_exp_t;
   logic        pclk;
   logic        presetn;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        nv_wr_strobe;
   logic        nv_rd_strobe;
   logic        nv_mem_sel;
   logic [7:0]  nv_addr_lo;
   logic [7:0]  nv_addr_hi;
   logic [7:0]  nv_wdata_lo;
   logic [7:0]  nv_wdata_hi;
   logic [7:0]  nv_rdata_lo;
   logic [7:0]  nv_rdata_hi;
   logic        cpu_stall;
   logic        write_busy;
   logic        serial_access_en;
   nvwp_exp_t   exp_q[$];
   nvwp_exp_t   mon_e;
   int          bad_count;
   int          compares;
   int          seed;
   int          wr_cnt;
   int          rd_cnt;
   int          busy_cyc;
   int          stall_cyc;
   logic [7:0]  a_lo;
   logic [7:0]  d_lo;
   logic [7:0]  a_hi;
   logic [7:0]  d_hi;
   logic [7:0]  c_tab[5];
   logic [7:0]  k1_tab[5];
   logic [7:0]  k2_tab[5];
   bit          pk_tab[5];
   bit          ok_tab[5];

   nvwp_ctrl #(.WRITE_CYCLES(WC), .PWRT_CYCLES(PW), .PWRT_ENABLE(1'b1)) u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nv_wr_strobe(nv_wr_strobe), .nv_rd_strobe(nv_rd_strobe), .nv_mem_sel(nv_mem_sel),
      .nv_addr_lo(nv_addr_lo), .nv_addr_hi(nv_addr_hi), .nv_wdata_lo(nv_wdata_lo),
      .nv_wdata_hi(nv_wdata_hi), .nv_rdata_lo(nv_rdata_lo), .nv_rdata_hi(nv_rdata_hi),
      .cpu_stall(cpu_stall), .write_busy(write_busy), .serial_access_en(serial_access_en)
   );

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic finish_test;
      $display("counts: %0d compares, %0d mismatches", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one apb transfer; the expected answer is noted for the monitor
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic err);
      nvwp_exp_t e;
      int        n;
      e.data = data;
      e.err = err;
      e.rd = !wr;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wr ? data : $random(seed);
      exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready", 32'h1, 32'h0);
         finish_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      apb(1'b1, addr, {24'h0, data}, 1'b0);
   endtask : wr

   task automatic rd(input logic [7:0] addr, input logic [7:0] data);
      apb(1'b0, addr, {24'h0, data}, 1'b0);
   endtask : rd

   // enable/select, two unlock bytes, optional stray write, then start
   task automatic try_write(input logic [7:0] c0, input logic [7:0] k1, input logic [7:0] k2,
                            input bit poke, input bit ok);
      int w0;
      int b0;
      int s0;
      int r0;
      w0 = wr_cnt;
      b0 = busy_cyc;
      s0 = stall_cyc;
      r0 = rd_cnt;
      wr(`NVWP_OFF_CTRL, c0);
      wr(`NVWP_OFF_UNLOCK, k1);
      wr(`NVWP_OFF_UNLOCK, k2);
      if (poke) wr(`NVWP_OFF_ADDR_LO, a_lo);
      wr(`NVWP_OFF_CTRL, c0 | 8'h02);
      repeat (WC + 8) @(posedge pclk);
      chk("write strobes", {31'h0, ok}, wr_cnt - w0);
      chk("busy cycles", ok ? WC : 0, busy_cyc - b0);
      chk("stall cycles", (ok && c0[7]) ? WC : 0, stall_cyc - s0);
      chk("reads during write", 32'h0, rd_cnt - r0);
      chk("write word", {a_hi, a_lo, d_hi, d_lo}, {nv_addr_hi, nv_addr_lo, nv_wdata_hi, nv_wdata_lo});
      chk("memory select", {31'h0, c0[7]}, {31'h0, nv_mem_sel});
      rd(`NVWP_OFF_CTRL, c0 | (ok ? 8'h10 : 8'h00));
   endtask : try_write

   task automatic do_reset;
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   // answer monitor and output event counters
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unexpected answer", 32'h0, 32'h1);
         end else begin
            mon_e = exp_q.pop_front();
            chk("pslverr", {31'h0, mon_e.err}, {31'h0, pslverr});
            if (mon_e.rd) chk("prdata", mon_e.data, prdata);
         end
      end
      if (nv_wr_strobe === 1'b1) wr_cnt++;
      if (nv_rd_strobe === 1'b1) rd_cnt++;
      if (write_busy === 1'b1) busy_cyc++;
      if (cpu_stall === 1'b1) stall_cyc++;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      finish_test();
   end

   initial begin
      seed = 32'h06ECAB9E;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      nv_rdata_lo = 8'h00;
      nv_rdata_hi = 8'h00;
      a_lo = 8'h00;
      d_lo = 8'h00;
      a_hi = 8'h00;
      d_hi = 8'h00;
      c_tab = '{8'h00, 8'h04, 8'h04, 8'h04, 8'h84};
      k1_tab = '{8'h55, 8'hAA, 8'h55, 8'h55, 8'h55};
      k2_tab = '{8'hAA, 8'h55, 8'hAA, 8'hAA, 8'hAA};
      pk_tab = '{0, 0, 1, 0, 0};
      ok_tab = '{0, 0, 0, 1, 1};
      do_reset();
      rd(`NVWP_OFF_CTRL, 8'h00);
      try_write(8'h04, 8'h55, 8'hAA, 0, 0);
      chk("serial access", 32'h1, {31'h0, serial_access_en});
      rd(`NVWP_OFF_PROT, 8'h07);
      rd(`NVWP_OFF_UNLOCK, 8'h00);
      apb(1'b0, 8'h1C, 32'h0, 1'b1);
      $display("test power-up done");
      repeat (PW) @(posedge pclk);
      a_lo = 8'($random(seed));
      d_lo = 8'($random(seed));
      a_hi = 8'($random(seed));
      d_hi = 8'($random(seed));
      wr(`NVWP_OFF_ADDR_LO, a_lo);
      wr(`NVWP_OFF_DATA_LO, d_lo);
      wr(`NVWP_OFF_ADDR_HI, a_hi);
      wr(`NVWP_OFF_DATA_HI, d_hi);
      rd(`NVWP_OFF_ADDR_LO, a_lo);
      for (int i = 0; i < 5; i++) begin
         try_write(c_tab[i], k1_tab[i], k2_tab[i], pk_tab[i], ok_tab[i]);
      end
      $display("test unlock and write done");
      repeat (10) @(posedge pclk);
      rd(`NVWP_OFF_CTRL, 8'h94);
      wr(`NVWP_OFF_CTRL, 8'h84);
      rd(`NVWP_OFF_CTRL, 8'h84);
      $display("test done flag done");
      wr(`NVWP_OFF_PROT, 8'h00);
      @(posedge pclk);
      chk("serial access", 32'h0, {31'h0, serial_access_en});
      rd(`NVWP_OFF_PROT, 8'h00);
      try_write(8'h04, 8'h55, 8'hAA, 0, 1);
      wr(`NVWP_OFF_PROT, 8'h07);
      rd(`NVWP_OFF_PROT, 8'h00);
      @(posedge pclk);
      nv_rdata_lo <= 8'($random(seed));
      nv_rdata_hi <= 8'($random(seed));
      wr(`NVWP_OFF_CTRL, 8'h85);
      repeat (6) @(posedge pclk);
      rd(`NVWP_OFF_DATA_LO, nv_rdata_lo);
      rd(`NVWP_OFF_DATA_HI, nv_rdata_hi);
      wr(`NVWP_OFF_PROT, 8'h80);
      rd(`NVWP_OFF_PROT, 8'h07);
      @(posedge pclk);
      chk("serial access", 32'h1, {31'h0, serial_access_en});
      $display("test protection done");
      do_reset();
      rd(`NVWP_OFF_CTRL, 8'h00);
      $display("test second reset done");
      finish_test();
   end
endmodule : nv_memory_write_protect_test

// ==== verilog/nvwp_cfg.svh ====
`ifndef NVWP_CFG_SVH
`define NVWP_CFG_SVH
// register byte offsets
`define NVWP_OFF_CTRL    8'h00
`define NVWP_OFF_UNLOCK  8'h04
`define NVWP_OFF_ADDR_LO 8'h08
`define NVWP_OFF_ADDR_HI 8'h0C
`define NVWP_OFF_DATA_LO 8'h10
`define NVWP_OFF_DATA_HI 8'h14
`define NVWP_OFF_PROT    8'h18
// control register fields
`define NVWP_CTRL_RD     0
`define NVWP_CTRL_WR     1
`define NVWP_CTRL_WRITE_ENABLE_BIT   2
`define NVWP_CTRL_DONE   4
`define NVWP_CTRL_MSEL   7
// protection register fields
`define NVWP_PROT_DP     0
`define NVWP_PROT_PPL    1
`define NVWP_PROT_PPH    2
`define NVWP_PROT_PWA    3
`define NVWP_PROT_ERASE  7
// unlock key bytes
`define NVWP_KEY_FIRST   8'h55
`define NVWP_KEY_SECOND  8'hAA
// reset values
`define NVWP_PROT_OFF    1'b1
`define NVWP_BYTE_RST    8'h00
`define NVWP_WORD_RST    32'h00000000
// timing counts in pclk cycles
`define NVWP_WRITE_CYCLES 16
`define NVWP_PWRT_CYCLES  64
`endif

// ==== verilog/nvwp_ctrl.sv ====
// Operation
// - write end clears start bit, sets done
// - processor stalls during program memory write
// - write needs enable bit and 55h/AAh unlock
// - no automatic verify of written data
// - reset clears enable; power-up timer blocks writes
// - data EEPROM writable whatever its protect bit
// - data protect active disables serial programming
// - internal program reads ignore protect bits
// - protection stays until full device erase or reset
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`include "nvwp_cfg.svh"
module nvwp_ctrl #(
   parameter int WRITE_CYCLES = `NVWP_WRITE_CYCLES,
   parameter int PWRT_CYCLES  = `NVWP_PWRT_CYCLES,
   parameter bit PWRT_ENABLE  = 1'b1
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // memory array side
   output logic             nv_wr_strobe,
   output logic             nv_rd_strobe,
   output logic             nv_mem_sel,
   output logic      [7:0]  nv_addr_lo,
   output logic      [7:0]  nv_addr_hi,
   output logic      [7:0]  nv_wdata_lo,
   output logic      [7:0]  nv_wdata_hi,
   input  wire logic [7:0]  nv_rdata_lo,
   input  wire logic [7:0]  nv_rdata_hi,
   // core and programming port
   output logic             cpu_stall,
   output logic             write_busy,
   output logic             serial_access_en
);
   import nvwp_pkg::*;

   initial begin
      if (WRITE_CYCLES < 1 || WRITE_CYCLES > 4096) $error("write cycle count out of range");
      if (PWRT_CYCLES < 1 || PWRT_CYCLES > 4096) $error("power-up count out of range");
   end

   nvwp_unlock_t ul_state, next_ul_state;
   nvwp_wr_t     wr_state, next_wr_state;
   logic         wr_start, next_wr_start;
   logic         write_enable_bit, next_write_enable_bit;
   logic         write_done_flag, next_write_done_flag;
   logic         memory_select_bit, next_memory_select_bit;
   logic         rd_pending, next_rd_pending;
   logic [7:0]   addr_lo, next_addr_lo;
   logic [7:0]   addr_hi, next_addr_hi;
   logic [7:0]   data_lo, next_data_lo;
   logic [7:0]   data_hi, next_data_hi;
   logic         data_protect_bit, next_data_protect_bit;
   logic         program_protect_bit_low, next_program_protect_bit_low;
   logic         program_protect_bit_high, next_program_protect_bit_high;
   logic         program_write_allow_bit, next_program_write_allow_bit;
   logic [31:0]  next_prdata;
   logic         next_pready, next_pslverr;
   logic         next_wr_strobe, next_rd_strobe, next_stall;
   logic         acc, acc_wr, hit, wr_go, rd_req, erase_req;
   logic         pwrt_busy, wt_busy, wt_done;
   logic [31:0]  rmux;

   nvwp_timer #(.COUNT(PWRT_CYCLES), .START_BUSY(PWRT_ENABLE)) u_pwrt (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (1'b0),
      .busy    (pwrt_busy),
      .done    ()
   );

   nvwp_timer #(.COUNT(WRITE_CYCLES), .START_BUSY(1'b0)) u_wtimer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (wr_go),
      .busy    (wt_busy),
      .done    (wt_done)
   );

   always_comb begin
      acc       = psel && penable && pready;
      acc_wr    = acc && pwrite;
      hit       = (paddr == `NVWP_OFF_CTRL) || (paddr == `NVWP_OFF_UNLOCK) ||
                  (paddr == `NVWP_OFF_ADDR_LO) || (paddr == `NVWP_OFF_ADDR_HI) ||
                  (paddr == `NVWP_OFF_DATA_LO) || (paddr == `NVWP_OFF_DATA_HI) ||
                  (paddr == `NVWP_OFF_PROT);
      // start only when armed, enabled, past power-up, and idle
      wr_go     = acc_wr && (paddr == `NVWP_OFF_CTRL) && pwdata[`NVWP_CTRL_WR] &&
                  (ul_state == NVWP_UL_ARMED) && write_enable_bit && !pwrt_busy &&
                  (wr_state == NVWP_WR_IDLE);
      // data protect bit plays no part in wr_go
      rd_req    = acc_wr && (paddr == `NVWP_OFF_CTRL) && pwdata[`NVWP_CTRL_RD] &&
                  (wr_state == NVWP_WR_IDLE);
      erase_req = acc_wr && (paddr == `NVWP_OFF_PROT) && pwdata[`NVWP_PROT_ERASE];
      rmux = `NVWP_WORD_RST;
      case (paddr)
         `NVWP_OFF_CTRL: begin
            rmux[`NVWP_CTRL_WR]   = wr_start;
            rmux[`NVWP_CTRL_WRITE_ENABLE_BIT] = write_enable_bit;
            rmux[`NVWP_CTRL_DONE] = write_done_flag;
            rmux[`NVWP_CTRL_MSEL] = memory_select_bit;
         end
         `NVWP_OFF_ADDR_LO: rmux[7:0] = addr_lo;
         `NVWP_OFF_ADDR_HI: rmux[7:0] = addr_hi;
         `NVWP_OFF_DATA_LO: rmux[7:0] = data_lo;
         `NVWP_OFF_DATA_HI: rmux[7:0] = data_hi;
         `NVWP_OFF_PROT: begin
            rmux[`NVWP_PROT_DP]  = data_protect_bit;
            rmux[`NVWP_PROT_PPL] = program_protect_bit_low;
            rmux[`NVWP_PROT_PPH] = program_protect_bit_high;
            rmux[`NVWP_PROT_PWA] = program_write_allow_bit;
         end
         default: rmux = `NVWP_WORD_RST;
      endcase
   end

   always_comb begin
      next_ul_state                 = ul_state;
      next_wr_state                 = wr_state;
      next_wr_start                 = wr_start;
      next_write_enable_bit         = write_enable_bit;
      next_write_done_flag          = write_done_flag;
      next_memory_select_bit        = memory_select_bit;
      next_rd_pending               = nv_rd_strobe;
      next_addr_lo                  = addr_lo;
      next_addr_hi                  = addr_hi;
      next_data_lo                  = data_lo;
      next_data_hi                  = data_hi;
      next_data_protect_bit         = data_protect_bit;
      next_program_protect_bit_low  = program_protect_bit_low;
      next_program_protect_bit_high = program_protect_bit_high;
      next_program_write_allow_bit  = program_write_allow_bit;
      next_pready                   = psel && penable && !pready;
      next_pslverr                  = psel && penable && !pready && !hit;
      next_prdata                   = prdata;
      if (psel && penable && !pready && !pwrite) begin
         next_prdata = rmux;
      end
      // unlock sequence: any other write breaks it
      if (acc_wr) begin
         next_ul_state = NVWP_UL_IDLE;
         if (paddr == `NVWP_OFF_UNLOCK) begin
            if (pwdata[7:0] == `NVWP_KEY_FIRST) begin
               next_ul_state = NVWP_UL_FIRST;
            end else if (pwdata[7:0] == `NVWP_KEY_SECOND && ul_state == NVWP_UL_FIRST) begin
               next_ul_state = NVWP_UL_ARMED;
            end
         end
      end
      if (acc_wr && hit) begin
         case (paddr)
            `NVWP_OFF_CTRL: begin
               next_write_enable_bit = pwdata[`NVWP_CTRL_WRITE_ENABLE_BIT];
               if (!pwdata[`NVWP_CTRL_DONE]) begin
                  next_write_done_flag = 1'b0;
               end
               if (wr_state == NVWP_WR_IDLE) begin
                  next_memory_select_bit = pwdata[`NVWP_CTRL_MSEL];
               end
            end
            `NVWP_OFF_ADDR_LO: next_addr_lo = pwdata[7:0];
            `NVWP_OFF_ADDR_HI: next_addr_hi = pwdata[7:0];
            `NVWP_OFF_DATA_LO: next_data_lo = pwdata[7:0];
            `NVWP_OFF_DATA_HI: next_data_hi = pwdata[7:0];
            `NVWP_OFF_PROT: begin
               // protect bits only move toward protected
               next_data_protect_bit         = data_protect_bit & pwdata[`NVWP_PROT_DP];
               next_program_protect_bit_low  = program_protect_bit_low & pwdata[`NVWP_PROT_PPL];
               next_program_protect_bit_high = program_protect_bit_high & pwdata[`NVWP_PROT_PPH];
               next_program_write_allow_bit  = pwdata[`NVWP_PROT_PWA];
            end
            default: next_addr_lo = addr_lo;
         endcase
      end
      if (erase_req) begin
         next_data_protect_bit         = `NVWP_PROT_OFF;
         next_program_protect_bit_low  = `NVWP_PROT_OFF;
         next_program_protect_bit_high = `NVWP_PROT_OFF;
      end
      // read result lands in the data registers
      if (rd_pending) begin
         next_data_lo = nv_rdata_lo;
         next_data_hi = nv_rdata_hi;
      end
      // write sequencer; data goes out unchecked, no read-back
      case (wr_state)
         NVWP_WR_IDLE: begin
            if (wr_go) begin
               next_wr_start = 1'b1;
               next_wr_state = NVWP_WR_BUSY;
            end
         end
         NVWP_WR_BUSY: begin
            if (wt_done) begin
               next_wr_start        = 1'b0;
               next_write_done_flag = 1'b1;
               next_wr_state        = NVWP_WR_IDLE;
            end
         end
         default: next_wr_state = NVWP_WR_IDLE;
      endcase
      next_wr_strobe = wr_go;
      next_rd_strobe = rd_req;
      next_stall     = (next_wr_state == NVWP_WR_BUSY) && next_memory_select_bit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ul_state                 <= NVWP_UL_IDLE;
         wr_state                 <= NVWP_WR_IDLE;
         wr_start                 <= 1'b0;
         write_enable_bit         <= 1'b0;
         write_done_flag          <= 1'b0;
         memory_select_bit        <= 1'b0;
         rd_pending               <= 1'b0;
         addr_lo                  <= `NVWP_BYTE_RST;
         addr_hi                  <= `NVWP_BYTE_RST;
         data_lo                  <= `NVWP_BYTE_RST;
         data_hi                  <= `NVWP_BYTE_RST;
         data_protect_bit         <= `NVWP_PROT_OFF;
         program_protect_bit_low  <= `NVWP_PROT_OFF;
         program_protect_bit_high <= `NVWP_PROT_OFF;
         program_write_allow_bit  <= 1'b0;
         prdata                   <= `NVWP_WORD_RST;
         pready                   <= 1'b0;
         pslverr                  <= 1'b0;
         nv_wr_strobe             <= 1'b0;
         nv_rd_strobe             <= 1'b0;
         cpu_stall                <= 1'b0;
         write_busy               <= 1'b0;
         serial_access_en         <= `NVWP_PROT_OFF;
      end else begin
         ul_state                 <= next_ul_state;
         wr_state                 <= next_wr_state;
         wr_start                 <= next_wr_start;
         write_enable_bit         <= next_write_enable_bit;
         write_done_flag          <= next_write_done_flag;
         memory_select_bit        <= next_memory_select_bit;
         rd_pending               <= next_rd_pending;
         addr_lo                  <= next_addr_lo;
         addr_hi                  <= next_addr_hi;
         data_lo                  <= next_data_lo;
         data_hi                  <= next_data_hi;
         data_protect_bit         <= next_data_protect_bit;
         program_protect_bit_low  <= next_program_protect_bit_low;
         program_protect_bit_high <= next_program_protect_bit_high;
         program_write_allow_bit  <= next_program_write_allow_bit;
         prdata                   <= next_prdata;
         pready                   <= next_pready;
         pslverr                  <= next_pslverr;
         nv_wr_strobe             <= next_wr_strobe;
         nv_rd_strobe             <= next_rd_strobe;
         cpu_stall                <= next_stall;
         write_busy               <= (next_wr_state == NVWP_WR_BUSY);
         serial_access_en         <= next_data_protect_bit;
      end
   end

   assign nv_mem_sel  = memory_select_bit;
   assign nv_addr_lo  = addr_lo;
   assign nv_addr_hi  = addr_hi;
   assign nv_wdata_lo = data_lo;
   assign nv_wdata_hi = data_hi;

   property p_done_sets_flag;
      @(posedge pclk) disable iff (!presetn)
      (wr_state == NVWP_WR_BUSY && wt_done) |=> (write_done_flag && !wr_start && !write_busy);
   endproperty
   a_done_sets_flag: assert property (p_done_sets_flag) else $error("write end not flagged");

   property p_flag_sticky;
      @(posedge pclk) disable iff (!presetn)
      (write_done_flag && !(acc_wr && paddr == `NVWP_OFF_CTRL && !pwdata[`NVWP_CTRL_DONE])) |=> write_done_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("done flag lost");

   property p_stall_prog;
      @(posedge pclk) disable iff (!presetn)
      (write_busy && nv_mem_sel) |-> cpu_stall;
   endproperty
   a_stall_prog: assert property (p_stall_prog) else $error("no stall in program write");

   property p_unlock_gate;
      @(posedge pclk) disable iff (!presetn)
      nv_wr_strobe |-> ($past(ul_state) == NVWP_UL_ARMED && $past(write_enable_bit) && write_busy);
   endproperty
   a_unlock_gate: assert property (p_unlock_gate) else $error("write without unlock");

   property p_pwrt_block;
      @(posedge pclk) disable iff (!presetn)
      $past(pwrt_busy) |-> !nv_wr_strobe;
   endproperty
   a_pwrt_block: assert property (p_pwrt_block) else $error("write during power-up");

   property p_data_free;
      @(posedge pclk) disable iff (!presetn)
      (acc_wr && paddr == `NVWP_OFF_DATA_LO && !rd_pending) |=> (nv_wdata_lo == $past(pwdata[7:0]));
   endproperty
   a_data_free: assert property (p_data_free) else $error("data write refused");

   property p_serial;
      @(posedge pclk) disable iff (!presetn)
      !data_protect_bit |-> !serial_access_en;
   endproperty
   a_serial: assert property (p_serial) else $error("serial access while protected");

   property p_read_any;
      @(posedge pclk) disable iff (!presetn)
      rd_req |=> nv_rd_strobe ##1 rd_pending;
   endproperty
   a_read_any: assert property (p_read_any) else $error("internal read lost");

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
      (!program_protect_bit_low && !erase_req) |=> !program_protect_bit_low;
   endproperty
   a_sticky: assert property (p_sticky) else $error("protection dropped");

   c_write_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(write_done_flag));
   c_prog_stall: cover property (@(posedge pclk) disable iff (!presetn) $rose(cpu_stall));
   c_armed:      cover property (@(posedge pclk) disable iff (!presetn) ul_state == NVWP_UL_ARMED);
   c_erase:      cover property (@(posedge pclk) disable iff (!presetn) erase_req && !data_protect_bit);
endmodule : nvwp_ctrl

// ==== verilog/nvwp_pkg.sv ====
package nvwp_pkg;
   typedef enum logic [2:0] {
      NVWP_UL_IDLE  = 3'b001,
      NVWP_UL_FIRST = 3'b010,
      NVWP_UL_ARMED = 3'b100
   } nvwp_unlock_t;
   typedef enum logic [1:0] {
      NVWP_WR_IDLE = 2'b01,
      NVWP_WR_BUSY = 2'b10
   } nvwp_wr_t;
endpackage : nvwp_pkg

// ==== verilog/nvwp_timer.sv ====
module nvwp_timer #(
   parameter int COUNT      = 16,
   parameter bit START_BUSY = 1'b0,
   parameter int WIDTH      = $clog2(COUNT + 1)
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   localparam logic [WIDTH-1:0] LOAD = WIDTH'(COUNT);
   localparam logic [WIDTH-1:0] INIT = START_BUSY ? WIDTH'(COUNT) : '0;
   localparam logic [WIDTH-1:0] ONE  = WIDTH'(1);

   logic [WIDTH-1:0] cnt;
   logic [WIDTH-1:0] next_cnt;

   initial begin
      if (COUNT < 1) $error("timer count must be at least one");
   end

   always_comb begin
      next_cnt = cnt;
      if (start) begin
         next_cnt = LOAD;
      end else if (cnt != '0) begin
         next_cnt = cnt - ONE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= INIT;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign busy = (cnt != '0);
   assign done = (cnt == ONE);
endmodule : nvwp_timer
